// ### logic/osw_pkg.sv
package osw_pkg;
	localparam int CHANNELS = 8;
	localparam int SERIAL_CHANNELS = 6;
	localparam int BYTE_BITS = 8;
	localparam int CLK_PERIOD_NS = 40;
	// detection and retry durations are not fixed by the part; plain defaults
	localparam int SHORT_SENSE_TIME_NS = 10000;
	localparam int OPEN_SENSE_TIME_NS = 20000;
	localparam int RETRY_OFF_TIME_NS = 80000;
	// least times round up to whole cycles
	localparam int SHORT_SENSE_CYC = (SHORT_SENSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OPEN_SENSE_CYC = (OPEN_SENSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_OFF_CYC = (RETRY_OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 12;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] FAULT_RESET = 8'h00;
	localparam int CMD_ONDET_LO = 6;
	localparam int CMD_ONDET_HI = 7;
	localparam int SYNC_W = 29;
endpackage

// ### logic/osw_sync.sv
`timescale 1ns/1ps
module osw_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// meta feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ### logic/osw_ctrl.sv
`timescale 1ns/1ps
module osw_ctrl #(
	parameter int SHORT_SENSE_CYC = osw_pkg::SHORT_SENSE_CYC,
	parameter int OPEN_SENSE_CYC = osw_pkg::OPEN_SENSE_CYC,
	parameter int RETRY_OFF_CYC = osw_pkg::RETRY_OFF_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic override_sel,
	input wire logic [7:0] parallel_channel_inputs,
	input wire logic [2:0] override_pair_inputs,
	input wire logic [7:0] short_flag,
	input wire logic [7:0] open_flag,
	output logic [7:0] switch_channels,
	output logic [7:0] channel_fault_flags,
	output logic [7:0] channel_command_bits
);
	localparam int TW = osw_pkg::TIMER_W;
	localparam logic [TW-1:0] SHORT_N = TW'(SHORT_SENSE_CYC);
	localparam logic [TW-1:0] OPEN_N = TW'(OPEN_SENSE_CYC);
	localparam logic [TW-1:0] RETRY_N = TW'(RETRY_OFF_CYC);

	generate
		if (SHORT_SENSE_CYC < 1 || SHORT_SENSE_CYC >= 2 ** TW ||
		    OPEN_SENSE_CYC < 1 || OPEN_SENSE_CYC >= 2 ** TW ||
		    RETRY_OFF_CYC < 1 || RETRY_OFF_CYC >= 2 ** TW) begin : g_bad_param
			$error("osw_ctrl: timer parameter out of range");
		end
	endgenerate

	// ---------------- link domain (shift clock) ----------------
	logic link_rst;
	logic loaded;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic so_bit;
	logic fell_once;
	logic frame_ok;
	logic [7:0] snap;

	// chip select high holds the frame logic idle; sclk never runs then
	assign link_rst = cs_n | rst;

	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			loaded <= 1'b0;
			bit_cnt <= 3'h0;
		end else begin
			loaded <= 1'b1;
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// first rising edge loads the frozen snapshot; every edge shifts si in
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			shreg <= 8'h00;
		end else if (!loaded) begin
			shreg <= {snap[6:0], si};
		end else begin
			shreg <= {shreg[6:0], si};
		end
	end

	// whole bytes only; survives chip select so the core can read it
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			frame_ok <= 1'b0;
		end else begin
			frame_ok <= (bit_cnt == 3'h7);
		end
	end

	always_ff @(negedge sclk or posedge link_rst) begin
		if (link_rst) begin
			so_bit <= 1'b0;
			fell_once <= 1'b0;
		end else begin
			so_bit <= shreg[7];
			fell_once <= 1'b1;
		end
	end

	// until the first falling edge the line shows the channel 7 fault bit
	always_comb begin
		so = fell_once ? so_bit : snap[7];
	end

	// ---------------- core domain ----------------
	logic [osw_pkg::SYNC_W-1:0] sync_in;
	logic [osw_pkg::SYNC_W-1:0] sync_out;
	logic cs_act;
	logic cs_act_d;
	logic cs_rise;
	logic ovr;
	logic [7:0] par;
	logic [2:0] pair;
	logic [7:0] shorted;
	logic [7:0] opened;
	logic [7:0] cmd;
	logic [7:0] fault;
	logic [7:0] qual;
	logic [7:0] qual_short;
	logic [7:0] retry_on;
	logic [7:0] next_demand;
	logic ondet_en;

	// inversion sits ahead of the synchroniser so reset reads as deselected
	assign sync_in = {~cs_n, override_sel, parallel_channel_inputs, override_pair_inputs,
		short_flag, open_flag};

	osw_sync #(
		.WIDTH(osw_pkg::SYNC_W)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d(sync_in),
		.q(sync_out)
	);

	assign cs_act = sync_out[28];
	assign ovr = sync_out[27];
	assign par = sync_out[26:19];
	assign pair = sync_out[18:16];
	assign shorted = sync_out[15:8];
	assign opened = sync_out[7:0];
	assign cs_rise = cs_act_d & ~cs_act;
	assign ondet_en = cmd[osw_pkg::CMD_ONDET_LO] | cmd[osw_pkg::CMD_ONDET_HI];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_act_d <= 1'b0;
		end else begin
			cs_act_d <= cs_act;
		end
	end

	// shreg and frame_ok are still while chip select is high, so a late
	// sample after the synchronised rise is safe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd <= osw_pkg::CMD_RESET;
		end else if (cs_rise && frame_ok) begin
			cmd <= shreg;
		end
	end

	// snapshot tracks the fault register while idle and freezes in a frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			snap <= osw_pkg::FAULT_RESET;
		end else if (!cs_act) begin
			snap <= fault;
		end
	end

	// bits shown in a completed frame are cleared; a fresh event wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault <= osw_pkg::FAULT_RESET;
		end else if (cs_rise) begin
			fault <= (fault & ~(frame_ok ? snap : 8'h00)) | qual;
		end else if (!cs_act) begin
			fault <= fault | qual;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			so_oe <= 1'b0;
		end else begin
			so_oe <= cs_act & ~ovr;
		end
	end

	always_comb begin
		if (ovr) begin
			next_demand[1:0] = {2{pair[0]}};
			next_demand[3:2] = {2{pair[1]}};
			next_demand[5:4] = {2{pair[2]}};
			next_demand[7:6] = 2'h0;
		end else begin
			next_demand[5:0] = cmd[5:0] | par[5:0];
			next_demand[7:6] = par[7:6];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			switch_channels <= 8'h00;
		end else begin
			switch_channels <= next_demand & ~retry_on;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			channel_fault_flags <= osw_pkg::FAULT_RESET;
			channel_command_bits <= osw_pkg::CMD_RESET;
		end else begin
			channel_fault_flags <= fault;
			channel_command_bits <= cmd;
		end
	end

	// per-channel qualification and short-circuit retry
	genvar gi;
	generate
		for (gi = 0; gi < osw_pkg::CHANNELS; gi++) begin : g_ch
			logic [TW-1:0] short_cnt;
			logic [TW-1:0] open_cnt;
			logic [TW-1:0] retry_cnt;
			logic short_cond;
			logic open_cond;
			logic open_on_ok;

			assign open_on_ok = (gi < osw_pkg::SERIAL_CHANNELS) && ondet_en;
			assign short_cond = shorted[gi] & switch_channels[gi];
			assign open_cond = opened[gi] & (~switch_channels[gi] | open_on_ok);
			assign qual_short[gi] = short_cond && (short_cnt == SHORT_N);
			assign qual[gi] = qual_short[gi] | (open_cond && (open_cnt == OPEN_N));
			assign retry_on[gi] = (retry_cnt != '0);

			// a transient shorter than the sense time restarts the count
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					short_cnt <= '0;
				end else if (!short_cond) begin
					short_cnt <= '0;
				end else if (short_cnt != SHORT_N) begin
					short_cnt <= short_cnt + TW'(1);
				end
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					open_cnt <= '0;
				end else if (!open_cond) begin
					open_cnt <= '0;
				end else if (open_cnt != OPEN_N) begin
					open_cnt <= open_cnt + TW'(1);
				end
			end

			// duty cycle is sense time on, retry time off, while the short stays
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					retry_cnt <= '0;
				end else if (!next_demand[gi]) begin
					retry_cnt <= '0;
				end else if (qual_short[gi]) begin
					retry_cnt <= RETRY_N;
				end else if (retry_cnt != '0) begin
					retry_cnt <= retry_cnt - TW'(1);
				end
			end
		end
	endgenerate

	// ---------------- checks ----------------
	chk_so_enable_cause: assert property (@(posedge clk) disable iff (rst)
		so_oe |-> $past(cs_act) && !$past(ovr))
		else $error("serial out enabled without select or under override");

	chk_faults_frozen: assert property (@(posedge clk) disable iff (rst)
		cs_act && $past(cs_act) |-> $stable(fault) && $stable(snap))
		else $error("fault register changed during a transfer");

	chk_cmd_load: assert property (@(posedge clk) disable iff (rst)
		cs_rise && frame_ok |=> cmd == $past(shreg))
		else $error("command not loaded at end of frame");

	chk_cmd_held: assert property (@(posedge clk) disable iff (rst)
		!cs_rise |=> $stable(cmd))
		else $error("command changed outside frame end");

	chk_override_off67: assert property (@(posedge clk) disable iff (rst)
		ovr |=> switch_channels[7:6] == 2'h0)
		else $error("channels 6 or 7 on during override");

	chk_override_pair: assert property (@(posedge clk) disable iff (rst)
		ovr && !retry_on[1] |=> switch_channels[1] == $past(pair[0]))
		else $error("channel 1 does not follow pair input 0");

	chk_or_control: assert property (@(posedge clk) disable iff (rst)
		!ovr && !retry_on[0] |=> switch_channels[0] == $past(cmd[0] | par[0]))
		else $error("channel 0 is not command or parallel");

	chk_ch6_parallel: assert property (@(posedge clk) disable iff (rst)
		!ovr && !retry_on[6] |=> switch_channels[6] == $past(par[6]))
		else $error("channel 6 not following its parallel input");

	chk_fault_sticky: assert property (@(posedge clk) disable iff (rst)
		|($past(fault) & ~fault) |-> $past(cs_rise) && $past(frame_ok))
		else $error("fault bit cleared without a completed read");

	chk_retry_shutoff: assert property (@(posedge clk) disable iff (rst)
		qual_short[0] && next_demand[0] |-> ##2 !switch_channels[0])
		else $error("shorted channel 0 not switched off for retry");

	// the snapshot must not lag the register by more than a cycle while idle
	chk_snap_track: assert property (@(posedge clk) disable iff (rst)
		!cs_act |=> snap == $past(fault))
		else $error("snapshot not tracking the fault register while idle");

	chk_ch7_parallel: assert property (@(posedge clk) disable iff (rst)
		!ovr && !retry_on[7] |=> switch_channels[7] == $past(par[7]))
		else $error("channel 7 not following its parallel input");

	chk_so_idle_off: assert property (@(posedge clk) disable iff (rst)
		!cs_act |=> !so_oe)
		else $error("serial out still enabled after deselect");
endmodule

// ### testbench/osw_host.sv
`timescale 1ns/1ps
module osw_host (
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so_line
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// shift clock stands low outside a frame; 30 ns period inside
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = '0;
		cs_n = 1'b0;
		#200;
		for (int i = n - 1; i >= 0; i--) begin
			si = tx[i];
			#15;
			sclk = 1'b1;
			rx = {rx[30:0], so_line};
			#15;
			sclk = 1'b0;
		end
		#15;
		cs_n = 1'b1;
		// a released line must not keep showing its last bit
		si = ~si;
		#200;
	endtask
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sclk, cs_n, si, so, so_oe;
	logic ovr = 1'b0;
	logic [7:0] par = 8'h00;
	logic [7:0] sf = 8'h00;
	logic [7:0] of = 8'h00;
	logic [2:0] pr = 3'h0;
	logic [7:0] sw, flt, cmd, tx;
	logic [31:0] rx;
	int n_fail = 0;
	int cmp_count = 0;
	// pull-up on the released serial output
	wire so_line = so_oe ? so : 1'b1;
	always #20 clk = ~clk;
	osw_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_line(so_line));
	osw_ctrl #(.SHORT_SENSE_CYC(4), .OPEN_SENSE_CYC(6), .RETRY_OFF_CYC(10)) uut (
		.clk(clk),
		.rst(rst),
		.sclk(sclk),
		.cs_n(cs_n),
		.si(si),
		.so(so),
		.so_oe(so_oe),
		.override_sel(ovr),
		.parallel_channel_inputs(par),
		.override_pair_inputs(pr),
		.short_flag(sf),
		.open_flag(of),
		.switch_channels(sw),
		.channel_fault_flags(flt),
		.channel_command_bits(cmd)
	);
	function automatic logic [7:0] exp_sw(logic o, logic [7:0] c, logic [7:0] p, logic [2:0] q);
		if (o)
			return {2'h0, {2{q[2]}}, {2{q[1]}}, {2{q[0]}}};
		return {p[7:6], p[5:0] | c[5:0]};
	endfunction
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic frame(int n, logic [31:0] t);
		host.xfer(n, t, rx);
		wt(4);
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		void'($urandom(5414));
		wt(20);
		rst = 1'b0;
		wt(2);
		chk("sw", sw, 8'h00);
		chk("cmd", cmd, 8'h00);
		chk("oe", so_oe, 1'b0);
		for (int k = 0; k < 12; k++) begin
			tx = (k == 0) ? 8'hff : 8'($urandom);
			par = (k == 1) ? 8'h00 : 8'($urandom);
			frame(8, tx);
			chk("rx8", rx, 32'h0000_0000);
			chk("cmd", cmd, tx);
			chk("sw", sw, exp_sw(1'b0, tx, par, pr));
			chk("oe", so_oe, 1'b0);
		end
		tx = 8'($urandom);
		frame(16, {tx, 8'h2a});
		chk("rx16", rx, {24'h00_0000, tx});
		chk("cmd16", cmd, 8'h2a);
		frame(32, 32'h1234_5678);
		chk("rx32", rx, 32'h0012_3456);
		chk("cmd32", cmd, 8'h78);
		// odd length frames must leave the command alone
		frame(12, 32'h0000_0f00);
		chk("cmd12", cmd, 8'h78);
		frame(8, 32'h0000_0000);
		par = 8'h00;
		of = 8'h40;
		wt(2);
		of = 8'h00;
		wt(20);
		chk("flt", flt, 8'h00);
		of = 8'h40;
		wt(20);
		of = 8'h00;
		wt(10);
		chk("flt", flt, 8'h40);
		frame(8, 32'h0000_0000);
		chk("rxf", rx, 32'h0000_0040);
		chk("flt", flt, 8'h00);
		par = 8'h01;
		wt(8);
		// a short shorter than the sense time leaves no trace
		sf = 8'h01;
		wt(2);
		sf = 8'h00;
		wt(8);
		chk("flt0", flt[0], 1'b0);
		chk("sw0", sw[0], 1'b1);
		sf = 8'h01;
		wt(11);
		chk("sw0", sw[0], 1'b0);
		chk("flt0", flt[0], 1'b1);
		sf = 8'h00;
		wt(30);
		chk("sw0", sw[0], 1'b1);
		// a frame of odd length is not a read and clears nothing
		frame(12, 32'h0000_0000);
		chk("flt12", flt, 8'h01);
		frame(8, 32'h0000_0000);
		chk("rx0", rx, 32'h0000_0001);
		// open while on counts only with a detect-enable bit, and never on 6 or 7
		par = 8'h41;
		of = 8'h41;
		wt(20);
		chk("flt", flt, 8'h00);
		frame(8, 32'h0000_0041);
		wt(10);
		chk("flt", flt, 8'h01);
		chk("sw", sw, exp_sw(1'b0, 8'h41, par, pr));
		of = 8'h00;
		ovr = 1'b1;
		par = 8'($urandom);
		pr = 3'($urandom);
		wt(8);
		chk("swo", sw, exp_sw(1'b1, 8'h41, par, pr));
		tx = 8'($urandom);
		frame(8, tx);
		chk("rxo", rx, 32'h0000_00ff);
		chk("cmdo", cmd, tx);
		chk("swo", sw, exp_sw(1'b1, tx, par, pr));
		ovr = 1'b0;
		wt(8);
		chk("swn", sw, exp_sw(1'b0, tx, par, pr));
		report_and_stop;
	end
	initial begin
		#400000;
		n_fail++;
		report_and_stop;
	end
endmodule
